//--- pkg/rlia_pkg.sv
// Purpose : Shared constants for the logical input action block
// Assumes : 100 MHz processing clock
// Notes   : Reset values equal the defaults of unassigned inputs
package rlia_pkg;
    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int unsigned CLOCK_HZ          = 100_000_000;
    localparam int unsigned DISPLAY_PERIOD_MS = 1000;
    localparam int unsigned DISPLAY_CYCLES    = CLOCK_HZ / 1000 * DISPLAY_PERIOD_MS;
    localparam int unsigned TEST_STEP_CYCLES  = 16;

    // ****************************************************************
    // Defaults and widths
    // ****************************************************************
    localparam logic NEG_SEQ_DEFAULT = 1'b1;
    localparam logic INPUT_DEFAULT   = 1'b0;
    localparam int   COUNT_W         = 16;
    localparam int   STEP_W          = 3;
    localparam logic [COUNT_W-1:0] COUNT_CLEAR = 16'h0000;
    localparam logic [STEP_W-1:0]  STEP_FIRST  = 3'h1;

    // ****************************************************************
    // Breaker state encoding
    // ****************************************************************
    typedef enum logic [1:0] {
        RLIA_CB_UNKNOWN = 2'h0,
        RLIA_CB_OPEN    = 2'h1,
        RLIA_CB_CLOSED  = 2'h2
    } rlia_cb_t;

    // Test sequence states
    typedef enum logic [1:0] {
        RLIA_T_IDLE,
        RLIA_T_TRIP,
        RLIA_T_RECLOSE,
        RLIA_T_WAIT
    } rlia_test_t;
endpackage

//--- hdl/rlia_edge.sv
// Purpose : Registers one logical input and flags its rising edge
// Assumes : Input already synchronous to clock
// Notes   : Reset level is the input's unassigned default
module rlia_edge
    import rlia_pkg::*;
#(
    parameter logic DEFAULT = 1'b0
) (
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic din,
    output logic      level,
    output logic      rise
);
    logic prev;

    assign rise = level & ~prev;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            level <= DEFAULT;
            prev  <= DEFAULT;
        end else begin
            level <= din;
            prev  <= level;
        end
    end
endmodule

//--- hdl/rlia_top.sv
// Purpose : Turns relay logical control inputs into protection actions
// Assumes : All inputs synchronous to clock; unassigned inputs tied to default
// Notes   : Element, recloser and breaker failure timing live elsewhere
//
// Overview of operation
// - Multi-shot reclose is enabled while its input is high and the breaker aux contacts show it open.
// - While the open request is high the master trip output is asserted.
// - While the close request is high the close output is asserted.
// - A rise of the first event capture input logs one event for it.
// - A rise of the second event capture input logs one event for it.
// - A rise of the waveform capture input starts one oscillographic capture.
// - Negative sequence overcurrent is enabled while its input is high, default high.
// - The counter clear input returns reclose and overcurrent counters to zero.
// - The user display input alternates message and default display every second.
// - The external start input starts the breaker failure tripping sequence.
// - The breaker fail initiate input starts the breaker failure trip logic.
// - A rise of the test input starts a trip followed by an automatic reclose.
// - While the test input stays high, trip and reclose repeat through the steps.
// - A pulse on the test input gives one trip and reclose only.
// - Breaker is open for aux 0/1, closed for 1/0 and unknown when they are equal.
module rlia_top
    import rlia_pkg::*;
#(
    parameter int unsigned DISPLAY_TICKS = DISPLAY_CYCLES,
    parameter int unsigned STEP_TICKS    = TEST_STEP_CYCLES,
    parameter int unsigned LAST_STEP     = 4
) (
    input  wire logic          clock,
    input  wire logic          resetn,
    input  wire logic          multi_shot_reclose_enable,
    input  wire logic          open_request,
    input  wire logic          close_request,
    input  wire logic          event_capture_first,
    input  wire logic          event_capture_second,
    input  wire logic          waveform_capture_trigger,
    input  wire logic          neg_seq_enable,
    input  wire logic          counter_clear_request,
    input  wire logic          user_display_request,
    input  wire logic          external_failure_start,
    input  wire logic          breaker_fail_initiate,
    input  wire logic          trip_reclose_test,
    input  wire logic          breaker_aux_normally_open,
    input  wire logic          breaker_aux_normally_closed,
    input  wire logic          reclose_count_inc,
    input  wire logic          overcurrent_count_inc,
    output logic               master_trip,
    output logic               close_out,
    output logic               multi_shot_active,
    output logic               event_log_first,
    output logic               event_log_second,
    output logic               waveform_start,
    output logic               neg_seq_protect_en,
    output logic [COUNT_W-1:0] reclose_count,
    output logic [COUNT_W-1:0] overcurrent_count,
    output logic               show_user_message,
    output logic               failure_start,
    output logic [1:0]         breaker_state,
    output logic [STEP_W-1:0]  reclose_step
);
    // ****************************************************************
    // Input sampling
    // ****************************************************************
    logic ec1_lvl, ec1_rise, ec2_lvl, ec2_rise, wc_lvl, wc_rise, tst_lvl, tst_rise;

    rlia_edge #(.DEFAULT(INPUT_DEFAULT)) u_ec1 (
        .clock(clock), .resetn(resetn), .din(event_capture_first),
        .level(ec1_lvl), .rise(ec1_rise));
    rlia_edge #(.DEFAULT(INPUT_DEFAULT)) u_ec2 (
        .clock(clock), .resetn(resetn), .din(event_capture_second),
        .level(ec2_lvl), .rise(ec2_rise));
    rlia_edge #(.DEFAULT(INPUT_DEFAULT)) u_wc (
        .clock(clock), .resetn(resetn), .din(waveform_capture_trigger),
        .level(wc_lvl), .rise(wc_rise));
    rlia_edge #(.DEFAULT(INPUT_DEFAULT)) u_tst (
        .clock(clock), .resetn(resetn), .din(trip_reclose_test),
        .level(tst_lvl), .rise(tst_rise));

    // ****************************************************************
    // Breaker position
    // ****************************************************************
    rlia_cb_t next_cb;
    assign next_cb = (breaker_aux_normally_open == breaker_aux_normally_closed) ?
                     RLIA_CB_UNKNOWN :
                     (breaker_aux_normally_open ? RLIA_CB_CLOSED : RLIA_CB_OPEN);

    // ****************************************************************
    // Trip and reclose test sequence
    // ****************************************************************
    rlia_test_t          tstate, next_tstate;
    logic [31:0]         tcount;
    logic [STEP_W-1:0]   next_step;
    logic                tdone;
    logic                seq_trip, seq_close;

    assign tdone     = (tcount >= STEP_TICKS - 1);
    assign seq_trip  = (tstate == RLIA_T_TRIP);
    assign seq_close = (tstate == RLIA_T_RECLOSE);

    always_comb begin
        next_tstate = tstate;
        next_step   = reclose_step;
        unique case (tstate)
            RLIA_T_IDLE: begin
                if (tst_rise) begin
                    next_tstate = RLIA_T_TRIP;
                    next_step   = STEP_FIRST;
                end
            end
            RLIA_T_TRIP: begin
                if (tdone) next_tstate = RLIA_T_RECLOSE;
            end
            RLIA_T_RECLOSE: begin
                if (tdone) next_tstate = RLIA_T_WAIT;
            end
            RLIA_T_WAIT: begin
                if (tdone) begin
                    if (tst_lvl && reclose_step < STEP_W'(LAST_STEP)) begin
                        next_tstate = RLIA_T_TRIP;
                        next_step   = reclose_step + STEP_W'(1);
                    end else begin
                        next_tstate = RLIA_T_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tstate       <= RLIA_T_IDLE;
            tcount       <= '0;
            reclose_step <= '0;
        end else begin
            tstate       <= next_tstate;
            tcount       <= (next_tstate != tstate) ? '0 : tcount + 32'd1;
            reclose_step <= next_step;
        end
    end

    // ****************************************************************
    // User display alternation
    // ****************************************************************
    logic [31:0] dcount;
    logic        dwrap;
    assign dwrap = (dcount >= DISPLAY_TICKS - 1);

    // Preloaded to the wrap point so the first request cycle flips to the message
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dcount            <= 32'(DISPLAY_TICKS - 1);
            show_user_message <= 1'b0;
        end else if (!user_display_request) begin
            dcount            <= 32'(DISPLAY_TICKS - 1);
            show_user_message <= 1'b0;
        end else if (dwrap) begin
            dcount            <= '0;
            show_user_message <= ~show_user_message;
        end else begin
            dcount            <= dcount + 32'd1;
        end
    end

    // ****************************************************************
    // Counters
    // ****************************************************************
    // Clear has priority: a count arriving during clear is dropped on purpose
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reclose_count     <= COUNT_CLEAR;
            overcurrent_count <= COUNT_CLEAR;
        end else if (counter_clear_request) begin
            reclose_count     <= COUNT_CLEAR;
            overcurrent_count <= COUNT_CLEAR;
        end else begin
            reclose_count     <= reclose_count + COUNT_W'(reclose_count_inc);
            overcurrent_count <= overcurrent_count + COUNT_W'(overcurrent_count_inc);
        end
    end

    // ****************************************************************
    // Level actions and event pulses
    // ****************************************************************
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            master_trip        <= 1'b0;
            close_out          <= 1'b0;
            multi_shot_active  <= 1'b0;
            event_log_first    <= 1'b0;
            event_log_second   <= 1'b0;
            waveform_start     <= 1'b0;
            neg_seq_protect_en <= NEG_SEQ_DEFAULT;
            failure_start      <= 1'b0;
            breaker_state      <= RLIA_CB_UNKNOWN;
        end else begin
            master_trip        <= open_request | seq_trip;
            close_out          <= close_request | seq_close;
            multi_shot_active  <= multi_shot_reclose_enable
                                  & (next_cb == RLIA_CB_OPEN);
            event_log_first    <= ec1_rise;
            event_log_second   <= ec2_rise;
            waveform_start     <= wc_rise;
            neg_seq_protect_en <= neg_seq_enable;
            failure_start      <= external_failure_start
                                  | breaker_fail_initiate;
            breaker_state      <= next_cb;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    AST_TRIP: assert property (@(posedge clock) disable iff (!resetn)
        open_request |=> master_trip)
        else $error("open request did not trip");
    AST_CLOSE: assert property (@(posedge clock) disable iff (!resetn)
        close_request |=> close_out)
        else $error("close request did not close");
    AST_EC1: assert property (@(posedge clock) disable iff (!resetn)
        event_log_first |=> !event_log_first)
        else $error("event one logged twice");
    AST_EC2: assert property (@(posedge clock) disable iff (!resetn)
        $rose(event_capture_second) |-> ##2 event_log_second)
        else $error("event two not logged");
    AST_WAVE: assert property (@(posedge clock) disable iff (!resetn)
        $rose(waveform_capture_trigger) |-> ##2 waveform_start ##1 !waveform_start)
        else $error("capture start not single pulse");
    AST_NEG: assert property (@(posedge clock) disable iff (!resetn)
        ##1 neg_seq_protect_en == $past(neg_seq_enable))
        else $error("negative sequence enable mismatch");
    AST_CLR: assert property (@(posedge clock) disable iff (!resetn)
        counter_clear_request |=> reclose_count == COUNT_CLEAR
                                  && overcurrent_count == COUNT_CLEAR)
        else $error("counters not cleared");
    AST_BF: assert property (@(posedge clock) disable iff (!resetn)
        (external_failure_start || breaker_fail_initiate) |=> failure_start)
        else $error("breaker failure not started");
    AST_CB: assert property (@(posedge clock) disable iff (!resetn)
        (breaker_aux_normally_open && !breaker_aux_normally_closed)
        |=> breaker_state == RLIA_CB_CLOSED)
        else $error("closed breaker not seen");
    AST_TEST: assert property (@(posedge clock) disable iff (!resetn)
        (tstate == RLIA_T_IDLE && tst_rise) |-> ##2 master_trip ##1 master_trip)
        else $error("test did not trip");
    AST_ONCE: assert property (@(posedge clock) disable iff (!resetn)
        (tstate == RLIA_T_WAIT && tdone && !tst_lvl) |=> tstate == RLIA_T_IDLE)
        else $error("pulsed test repeated");
    AST_MS: assert property (@(posedge clock) disable iff (!resetn)
        !multi_shot_reclose_enable |=> !multi_shot_active)
        else $error("multi shot without enable");

    // ****************************************************************
    // Checks on breaker position, level paths, event one logging and reclose counting
    // ****************************************************************
    AST_CB_OPEN: assert property (@(posedge clock) disable iff (!resetn)
        (!breaker_aux_normally_open && breaker_aux_normally_closed)
        |=> breaker_state == RLIA_CB_OPEN)
        else $error("open breaker not seen");
    AST_CB_UNK: assert property (@(posedge clock) disable iff (!resetn)
        (breaker_aux_normally_open == breaker_aux_normally_closed)
        |=> breaker_state == RLIA_CB_UNKNOWN)
        else $error("unknown breaker state not seen");
    AST_MS_ON: assert property (@(posedge clock) disable iff (!resetn)
        (multi_shot_reclose_enable && !breaker_aux_normally_open
         && breaker_aux_normally_closed) |=> multi_shot_active)
        else $error("multi shot not enabled on open breaker");
    // An idle sequence leaves trip and close to the requests alone
    AST_NO_TRIP: assert property (@(posedge clock) disable iff (!resetn)
        (!open_request && tstate == RLIA_T_IDLE) |=> !master_trip)
        else $error("trip without request");
    AST_NO_CLOSE: assert property (@(posedge clock) disable iff (!resetn)
        (!close_request && tstate == RLIA_T_IDLE) |=> !close_out)
        else $error("close without request");
    AST_BFI: assert property (@(posedge clock) disable iff (!resetn)
        breaker_fail_initiate |=> failure_start)
        else $error("breaker fail initiate not started");
    AST_EC1_LOG: assert property (@(posedge clock) disable iff (!resetn)
        $rose(event_capture_first) |-> ##2 event_log_first)
        else $error("event one not logged");
    // Clear wins, so only an uncleared cycle must count
    AST_CNT: assert property (@(posedge clock) disable iff (!resetn)
        (!counter_clear_request && reclose_count_inc)
        |=> reclose_count == $past(reclose_count) + COUNT_W'(1))
        else $error("reclose count did not advance");

    // ****************************************************************
    // Checks on display and test sequence
    // ****************************************************************
    AST_DISP_ON: assert property (@(posedge clock) disable iff (!resetn)
        $rose(user_display_request) |=> show_user_message)
        else $error("user message not shown");
    AST_DISP_OFF: assert property (@(posedge clock) disable iff (!resetn)
        !user_display_request |=> !show_user_message)
        else $error("user message without request");
    AST_STEP: assert property (@(posedge clock) disable iff (!resetn)
        (tstate == RLIA_T_IDLE && tst_rise) |=> reclose_step == STEP_FIRST)
        else $error("test did not start at first step");
    AST_HOLD: assert property (@(posedge clock) disable iff (!resetn)
        (tstate == RLIA_T_WAIT && tdone && tst_lvl
         && reclose_step < STEP_W'(LAST_STEP)) |=> tstate == RLIA_T_TRIP)
        else $error("held test did not advance");
    AST_RISE: assert property (@(posedge clock) disable iff (!resetn)
        tst_rise |=> !tst_rise)
        else $error("test rise seen twice");
endmodule

//--- sim/rlia_contacts.sv
// Purpose : Model of the contact inputs and feedback terms feeding the block
// Assumes : Bench requests levels; model applies them at the falling edge
// Notes   : Unassigned inputs sit at their defaults while reset is low
module rlia_contacts
    import rlia_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire logic [15:0] cmd,
    output logic      [15:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************************************
    // Contact levels
    // ****************************************************************
    // Only the neg sequence enable idles high when it is not assigned
    localparam logic [15:0] IDLE = {9'h000, NEG_SEQ_DEFAULT, 6'h00};
    // Manual breaker control goes through the open and close bits
    always @(negedge clock or negedge resetn) begin
        if (!resetn) begin
            pins <= IDLE;
        end else begin
            pins <= cmd;
        end
    end
endmodule

//--- sim/relay_logical_input_actions_bench.sv
// Purpose : Self-checking bench for the logical input action block
// Assumes : Short display and test step counts set at the instance
// Notes   : Bench changes requests after a rising edge, samples at the falling one
module relay_logical_input_actions_bench
    import rlia_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int unsigned DT = 20;
    localparam int unsigned ST = 4;
    localparam int unsigned LS = 3;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] cmd = {9'h000, NEG_SEQ_DEFAULT, 6'h00};
    logic [15:0] pins;
    logic master_trip, close_out, multi_shot_active, event_log_first, event_log_second;
    logic waveform_start, neg_seq_protect_en, show_user_message, failure_start;
    logic [COUNT_W-1:0] reclose_count, overcurrent_count;
    logic [1:0] breaker_state;
    logic [STEP_W-1:0] reclose_step;
    logic [8:0] obs;
    int fail_count = 0;
    int total_checks = 0;
    int nt, nc, c, h, i, k;
    logic [STEP_W-1:0] mx;
    logic [1:0] eb;
    int ci[4] = '{1, 2, 9, 10};
    int oi[4] = '{0, 1, 8, 8};
    assign obs = {failure_start, show_user_message, neg_seq_protect_en, waveform_start,
                  event_log_second, event_log_first, multi_shot_active, close_out, master_trip};
    always #5 clock = ~clock;
    rlia_contacts i_part (.clock(clock), .resetn(resetn), .cmd(cmd), .pins(pins));
    rlia_top #(.DISPLAY_TICKS(DT), .STEP_TICKS(ST), .LAST_STEP(LS)) i_dut (
        .clock(clock), .resetn(resetn), .multi_shot_reclose_enable(pins[0]),
        .open_request(pins[1]), .close_request(pins[2]), .event_capture_first(pins[3]),
        .event_capture_second(pins[4]), .waveform_capture_trigger(pins[5]),
        .neg_seq_enable(pins[6]), .counter_clear_request(pins[7]),
        .user_display_request(pins[8]), .external_failure_start(pins[9]),
        .breaker_fail_initiate(pins[10]), .trip_reclose_test(pins[11]),
        .breaker_aux_normally_open(pins[12]), .breaker_aux_normally_closed(pins[13]),
        .reclose_count_inc(pins[14]), .overcurrent_count_inc(pins[15]),
        .master_trip(master_trip), .close_out(close_out),
        .multi_shot_active(multi_shot_active), .event_log_first(event_log_first),
        .event_log_second(event_log_second), .waveform_start(waveform_start),
        .neg_seq_protect_en(neg_seq_protect_en), .reclose_count(reclose_count),
        .overcurrent_count(overcurrent_count), .show_user_message(show_user_message),
        .failure_start(failure_start), .breaker_state(breaker_state),
        .reclose_step(reclose_step));
    // ****************************************************************
    // Observers and tasks
    // ****************************************************************
    // Whole-window tallies so a trip and its reclose are seen in one pass
    always @(negedge clock) begin
        nt = nt + int'(master_trip === 1'b1);
        nc = nc + int'(close_out === 1'b1);
        if (reclose_step > mx) mx = reclose_step;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic pulse(input int b);
        cmd[b] = 1'b1;
        cyc(1);
        cmd[b] = 1'b0;
        cyc(1);
    endtask
    task automatic cnt(input int s, input int n, output int r);
        r = 0;
        repeat (n) begin
            @(negedge clock);
            r = r + int'(obs[s] === 1'b1);
        end
        @(posedge clock);
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkn(input string nm, input int e, input int g);
        total_checks++;
        if (g != e) begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        #50000;
        fail_count++;
        final_report();
    end
    initial begin
        cyc(10);
        @(negedge clock);
        resetn = 1'b1;
        @(negedge clock);
        chk("neg_seq_protect_en", 16'h0001, neg_seq_protect_en);
        chk("breaker_state", 16'h0000, breaker_state);
        chk("master_trip", 16'h0000, master_trip);
        chk("reclose_step", 16'h0000, reclose_step);
        $display("test reset done");
        cyc(1);
        for (i = 0; i < 4; i++) begin
            cmd[ci[i]] = 1'b1;
            cnt(oi[i], 3, c);
            chk("level on", 16'h0001, obs[oi[i]]);
            cmd[ci[i]] = 1'b0;
            cnt(oi[i], 3, c);
            chk("level off", 16'h0000, obs[oi[i]]);
        end
        cmd[6] = 1'b0;
        cnt(6, 3, c);
        chk("neg_seq_protect_en", 16'h0000, neg_seq_protect_en);
        cmd[6] = 1'b1;
        $display("test levels done");
        cmd[0] = 1'b1;
        for (k = 0; k < 4; k++) begin
            eb = k;
            cmd[12] = eb[1];
            cmd[13] = eb[0];
            cnt(0, 3, c);
            chk("breaker_state", (k == 1) ? RLIA_CB_OPEN : (k == 2) ? RLIA_CB_CLOSED
                : RLIA_CB_UNKNOWN, breaker_state);
            chk("multi_shot_active", k == 1, multi_shot_active);
        end
        cmd[0] = 1'b0;
        $display("test breaker done");
        for (i = 3; i < 6; i++) begin
            cmd[i] = 1'b1;
            cnt(i, 12, c);
            chkn("held event pulses", 1, c);
            cmd[i] = 1'b0;
            cyc(2);
            pulse(i);
            cnt(i, 8, c);
            chkn("pulsed event pulses", 1, c);
        end
        $display("test events done");
        repeat (3) pulse(14);
        repeat (2) pulse(15);
        cyc(2);
        chk("reclose_count", 16'h0003, reclose_count);
        chk("overcurrent_count", 16'h0002, overcurrent_count);
        cmd[7] = 1'b1;
        pulse(14);
        cyc(3);
        chk("reclose_count", COUNT_CLEAR, reclose_count);
        chk("overcurrent_count", COUNT_CLEAR, overcurrent_count);
        cmd[7] = 1'b0;
        $display("test counters done");
        cmd[8] = 1'b1;
        cnt(7, 3, c);
        chk("show_user_message", 16'h0001, show_user_message);
        for (k = 0; k < 2; k++) begin
            h = 0;
            @(negedge clock);
            while (obs[7] === 1'b1 && h < 100) begin
                @(negedge clock);
                h++;
            end
            h = 0;
            while (obs[7] === 1'b0 && h < 100) begin
                @(negedge clock);
                h++;
            end
            chkn("display low phase", DT, h);
        end
        cmd[8] = 1'b0;
        cnt(7, 2, c);
        chk("show_user_message", 16'h0000, show_user_message);
        $display("test display done");
        nt = 0;
        nc = 0;
        mx = '0;
        pulse(11);
        cyc(60);
        chkn("pulse trip cycles", ST, nt);
        chkn("pulse close cycles", ST, nc);
        chk("reclose_step", STEP_FIRST, mx);
        nt = 0;
        nc = 0;
        cmd[11] = 1'b1;
        cyc(100);
        cmd[11] = 1'b0;
        chkn("held trip cycles", LS * ST, nt);
        chkn("held close cycles", LS * ST, nc);
        chk("reclose_step", LS, mx);
        cyc(2);
        nt = 0;
        pulse(11);
        cyc(60);
        chkn("second pulse trip cycles", ST, nt);
        $display("test trip reclose done");
        final_report();
    end
endmodule
